// ==== bench/sarrd_host.sv ====
// host model: master frame receiver and slave clock source
`timescale 1ns/1ps
`default_nettype none
module sarrd_host (
  input  wire logic                   clk,
  input  wire sarrd_pkg::sarrd_tri_t  sync_p,
  input  wire sarrd_pkg::sarrd_tri_t  sclk_p,
  input  wire sarrd_pkg::sarrd_tri_t  sdo_p,
  input  wire logic                   rd_go,
  output logic                        ext_sclk,
  output logic                        rd_busy,
  output logic                        word_vld,
  output logic [15:0]                 word,
  output logic                        s_vld,
  output logic [15:0]                 s_word
);
  import sarrd_pkg::*;
  logic [2:0]  line;
  logic [2:0]  line_q = 3'h0;
  logic [15:0] sh_q   = 16'h0000;
  logic        oe_q   = 1'b0;
  // a floating line toggles every cycle so it never reads as data
  assign line = ({sync_p.o, sclk_p.o, sdo_p.o} & {sync_p.oe, sclk_p.oe, sdo_p.oe})
              | (~line_q & ~{sync_p.oe, sclk_p.oe, sdo_p.oe});
  always @(posedge clk) begin
    line_q   <= line;
    oe_q     <= sync_p.oe;
    word_vld <= 1'b0;
    if (line[1] && !line_q[1]) begin
      sh_q <= {sh_q[14:0], line[0]};
    end
    if (sync_p.oe && oe_q && line_q[2] && !line[2]) begin
      word     <= sh_q;
      word_vld <= 1'b1;
    end
  end
  // slave read: slow clock, data taken just before each falling edge
  initial begin
    ext_sclk = 1'b0;
    rd_busy  = 1'b0;
    s_vld    = 1'b0;
    s_word   = 16'h0000;
    forever begin
      @(posedge clk);
      if (rd_go) begin
        rd_busy = 1'b1;
        repeat (16) begin
          #2 ext_sclk = 1'b1;
          repeat (4) @(posedge clk);
          s_word = {s_word[14:0], line[0]};
          #2 ext_sclk = 1'b0;
          repeat (4) @(posedge clk);
        end
        #2 s_vld = 1'b1;
        @(posedge clk);
        #2 s_vld = 1'b0;
        rd_busy = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/sarrd_top_bench.sv ====
// self-checking bench for the converter readout block
`timescale 1ns/1ps
`default_nettype none
module sarrd_top_bench;
  import sarrd_pkg::*;
  logic              clk   = 1'b0;
  logic              rst_n = 1'b0;
  sarrd_pins_t       pr    = PINS_RST;
  sarrd_pins_t       pins;
  logic [RES_W-1:0]  res   = 16'h0000;
  logic [RES_W-1:0]  data;
  sarrd_tri_t        sync_w, sclk_w, sdo_w;
  logic              busy, xsclk, rbusy, mvld, svld, busy_p;
  logic              go    = 1'b0;
  logic [15:0]       mword, sword;
  logic [15:0]       exp_q[$];
  logic [15:0]       fq[$];
  int                errors = 0;
  int                total_checks = 0;
  int                cyc = 0;
  always #12.5 clk = ~clk;
  always_comb begin
    pins          = pr;
    pins.ext_sclk = xsclk;
  end
  sarrd_top #(.FIFO_WORDS(16)) dut (.CORE_CLK(clk), .RESET_N(rst_n), .PINS(pins), .ADC_RESULT(res),
    .BUSY(busy), .DATA(data), .SYNC(sync_w), .SCLK(sclk_w), .SERIAL_OUT_LINE(sdo_w));
  sarrd_host host (.clk(clk), .sync_p(sync_w), .sclk_p(sclk_w), .sdo_p(sdo_w), .rd_go(go), .ext_sclk(xsclk),
    .rd_busy(rbusy), .word_vld(mvld), .word(mword), .s_vld(svld), .s_word(sword));
  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic cmp_word(input logic [15:0] got);
    total_checks++;
    if (exp_q.size() == 0 || got !== exp_q[0]) begin
      errors++;
      $display("mismatch %0t word %h", $time, got);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask
  task automatic cmp_bit(input logic got, input logic e);
    total_checks++;
    if (got !== e) begin
      errors++;
      $display("mismatch %0t busy %b", $time, got);
    end
  endtask
  task automatic conclude();
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // results: parallel word at busy fall, serial words from the host model
  always @(posedge clk) begin
    cyc++;
    if (busy_p === 1'b1 && busy === 1'b0 && !pr.link_select) cmp_word(data);
    if (mvld === 1'b1) cmp_word(mword);
    if (svld === 1'b1) cmp_word(sword);
    busy_p = busy;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic conv(input bit run);
    logic [15:0] v;
    int          i;
    v = 16'($urandom);
    @(posedge clk);
    #2 res = v;
    pr.code_format_sel = 1'($urandom);
    v = v ^ {~pr.code_format_sel, 15'h0000};
    if (!pr.link_select || (!pr.slave_sel && pr.read_after)) exp_q.push_back(v);
    else begin
      if (!pr.slave_sel) exp_q.push_back(fq.size() != 0 ? fq.pop_front() : 16'h0000);
      if (run) fq.push_back(v);
    end
    pr.conv_start_n = 1'b0;
    repeat (3) @(posedge clk);
    #2 pr.conv_start_n = 1'b1;
    @(posedge clk);
    #2 cmp_bit(busy, run);
    for (i = 0; i < 300 && busy; i++) @(posedge clk);
    repeat (120) @(posedge clk);
    #2;
  endtask
  task automatic sread();
    int i;
    exp_q.push_back(fq.pop_front());
    @(posedge clk);
    #2 go = 1'b1;
    @(posedge clk);
    #2 go = 1'b0;
    for (i = 0; i < 200 && rbusy; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #2;
  endtask
  initial begin
    int k;
    void'($urandom(32'h0000_e1b1));
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    for (k = 0; k < 6; k++) conv(1'b1);
    pr.link_select = 1'b1;
    pr.cs_n = 1'b0;
    pr.read_after = 1'b1;
    for (k = 0; k < 4; k++) begin
      pr.serial_clock_divider = 2'(k);
      conv(1'b1);
    end
    pr.read_after = 1'b0;
    pr.serial_clock_divider = 2'b01;
    for (k = 0; k < 3; k++) conv(1'b1);
    pr.slave_sel = 1'b1;
    repeat (6) @(posedge clk);
    #2 sread();
    // one word sits in the shifter, sixteen fill the buffer, the next start is refused
    for (k = 0; k < 18; k++) conv(k < 17);
    for (k = 0; k < 17; k++) sread();
    pr.cs_n = 1'b1;
    repeat (8) @(posedge clk);
    if (exp_q.size() != 0) begin
      errors++;
      $display("mismatch %0t words missing", $time);
    end
    conclude();
  end
endmodule
`default_nettype wire

// ==== bench/sarrd_top_chk.sv ====
// concurrent checks on the converter readout ports
`timescale 1ns/1ps
`default_nettype none
module sarrd_top_chk #(
  parameter int FIFO_WORDS = 16
) (
  input wire logic                         CORE_CLK,
  input wire logic                         RESET_N,
  input wire sarrd_pkg::sarrd_pins_t       PINS,
  input wire logic [sarrd_pkg::RES_W-1:0]  ADC_RESULT,
  input wire logic                         BUSY,
  input wire logic [sarrd_pkg::RES_W-1:0]  DATA,
  input wire sarrd_pkg::sarrd_tri_t        SYNC,
  input wire sarrd_pkg::sarrd_tri_t        SCLK,
  input wire sarrd_pkg::sarrd_tri_t        SERIAL_OUT_LINE
);
  import sarrd_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic       busy_q, rac_q, sclk_q;
  logic [7:0] blen_q, run_q;
  logic [4:0] nf_q;
  wire  [1:0] dv   = PINS.serial_clock_divider;
  wire        mrac = PINS.link_select & ~PINS.slave_sel & PINS.read_after;
  wire        mrdc = PINS.link_select & ~PINS.slave_sel & ~PINS.read_after;
  wire  [7:0] half = dv[1] ? (dv[0] ? 8'h04 : 8'h02) : 8'h01;
  wire  [7:0] gap  = dv[1] ? (dv[0] ? 8'h0c : 8'h06) : (dv[0] ? 8'h03 : 8'h01);
  // busy ceilings in 25 ns cycles
  wire  [7:0] bmax = dv[1] ? (dv[0] ? 8'he6 : 8'h8c) : (dv[0] ? 8'h64 : 8'h50);
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_q <= 1'b0;
      blen_q <= 8'h00;
      rac_q  <= 1'b0;
    end else begin
      busy_q <= BUSY;
      blen_q <= BUSY ? blen_q + 8'h01 : 8'h00;
      if (BUSY && !busy_q) begin
        rac_q <= mrac;
      end
    end
  end
  // run length of the serial clock level, falls counted per frame
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk_q <= 1'b0;
      run_q  <= 8'h00;
      nf_q   <= 5'h00;
    end else begin
      sclk_q <= SCLK.o;
      run_q  <= (SCLK.o != sclk_q) ? 8'h01 : run_q + 8'h01;
      nf_q   <= !SYNC.o ? 5'h00 : nf_q + 5'((sclk_q && !SCLK.o) ? 1 : 0);
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_lead; !SCLK.o ##1 SCLK.o; endsequence
  sequence s_sel_on; (PINS.link_select && !PINS.slave_sel && !PINS.cs_n) [*4]; endsequence
  sequence s_busy_drop; BUSY ##1 !BUSY; endsequence
  property p_busy_rise; $fell(PINS.conv_start_n) && !BUSY && !PINS.link_select |-> ##[2:3] BUSY; endproperty
  property p_busy_len; $fell(BUSY) && !rac_q |-> blen_q == BUSY_FALL_CYC + 8'h01; endproperty
  property p_rac_max; $fell(BUSY) && rac_q |-> blen_q <= bmax; endproperty
  property p_data_lead; $changed(DATA) |-> s_busy_drop; endproperty
  property p_code; $changed(DATA) |-> DATA == (ADC_RESULT ^ {~PINS.code_format_sel, 15'h0000}); endproperty
  property p_rdc_sync; $rose(BUSY) && mrdc |-> ##[19:22] $rose(SYNC.o); endproperty
  property p_rac_sync; $rose(BUSY) && mrac |-> ##[45:47] $rose(SYNC.o); endproperty
  property p_rac_end; $fell(SYNC.o) && rac_q |-> s_busy_drop; endproperty
  property p_lead; $rose(SYNC.o) |-> s_lead; endproperty
  property p_half; SYNC.o && rac_q && $changed(SCLK.o) && (!SCLK.o || nf_q != 5'h00) |-> run_q == half; endproperty
  property p_gap; $fell(SYNC.o) && rac_q |-> nf_q == 5'h10 && run_q == gap && !SCLK.o; endproperty
  property p_oe_on; s_sel_on |-> SYNC.oe && SCLK.oe && SERIAL_OUT_LINE.oe; endproperty
  property p_oe_off; PINS.cs_n [*4] |-> !SYNC.oe && !SCLK.oe && !SERIAL_OUT_LINE.oe; endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy rise late");
  a_busy_len: assert property (p_busy_len) else $error("busy length");
  a_rac_max: assert property (p_rac_max) else $error("busy too long");
  a_data_lead: assert property (p_data_lead) else $error("data not ahead of busy");
  a_code: assert property (p_code) else $error("data coding");
  a_rdc_sync: assert property (p_rdc_sync) else $error("early frame timing");
  a_rac_sync: assert property (p_rac_sync) else $error("late frame timing");
  a_rac_end: assert property (p_rac_end) else $error("busy after frame");
  a_lead: assert property (p_lead) else $error("clock lead");
  a_half: assert property (p_half) else $error("clock half period");
  a_gap: assert property (p_gap) else $error("frame tail gap");
  a_oe_on: assert property (p_oe_on) else $error("drivers not on");
  a_oe_off: assert property (p_oe_off) else $error("drivers not off");
endmodule
bind sarrd_top sarrd_top_chk #(.FIFO_WORDS(FIFO_WORDS)) u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
  .PINS(PINS), .ADC_RESULT(ADC_RESULT), .BUSY(BUSY), .DATA(DATA), .SYNC(SYNC), .SCLK(SCLK), .SERIAL_OUT_LINE(SERIAL_OUT_LINE));
`default_nettype wire

// ==== core/sarrd_fifo.sv ====
// result FIFO between conversion and readout, first word fall-through
`timescale 1ns/1ps
`default_nettype none
module sarrd_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  // depth must be a power of two: pointers wrap by carrying into the extra bit
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         push;
  logic         pop;

  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready  = ~full;
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & out_valid;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
    end else if (push) begin
      wr_q <= wr_q + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ==== core/sarrd_top.sv ====
// conversion sequencing and parallel/serial result readout for a 16-bit converter
`timescale 1ns/1ps
`default_nettype none
module sarrd_top
  import sarrd_pkg::*;
#(
  parameter int FIFO_WORDS = sarrd_pkg::FIFO_DEPTH
) (
  input  wire logic                         CORE_CLK,
  input  wire logic                         RESET_N,
  input  wire sarrd_pkg::sarrd_pins_t       PINS,
  input  wire logic [sarrd_pkg::RES_W-1:0]  ADC_RESULT,
  output logic                              BUSY,
  output logic [sarrd_pkg::RES_W-1:0]       DATA,
  output sarrd_pkg::sarrd_tri_t             SYNC,
  output sarrd_pkg::sarrd_tri_t             SCLK,
  output sarrd_pkg::sarrd_tri_t             SERIAL_OUT_LINE
);
  import sarrd_pkg::*;

  typedef enum logic [1:0] {
    CV_IDLE,
    CV_CONV,
    CV_HOLD
  } sarrd_cv_t;

  typedef enum logic [1:0] {
    SR_IDLE,
    SR_LEAD,
    SR_SHIFT,
    SR_TAIL
  } sarrd_sr_t;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sarrd_pins_t pins_s1_q;
  sarrd_pins_t pins_s2_q;
  sarrd_pins_t pins_s3_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pins_s1_q <= PINS_RST;
      pins_s2_q <= PINS_RST;
      pins_s3_q <= PINS_RST;
    end else begin
      pins_s1_q <= PINS;
      pins_s2_q <= pins_s1_q;
      pins_s3_q <= pins_s2_q;
    end
  end

  logic start_fall;
  logic ext_fall;
  logic serial_mode;
  logic master_mode;
  logic cs_active;

  assign start_fall  = pins_s3_q.conv_start_n & ~pins_s2_q.conv_start_n;
  assign ext_fall    = pins_s3_q.ext_sclk & ~pins_s2_q.ext_sclk;
  assign serial_mode = pins_s2_q.link_select;
  assign master_mode = ~pins_s2_q.slave_sel;
  assign cs_active   = ~pins_s2_q.cs_n;

  // ---------------------------------------------------------------
  // result FIFO
  // ---------------------------------------------------------------
  sarrd_cv_t         cv_q;
  sarrd_sr_t         sr_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              rac_q;
  logic              busy_q;
  logic              f_in_valid;
  logic              f_in_ready;
  logic [RES_W-1:0]  f_in_data;
  logic              f_out_valid;
  logic              f_out_ready;
  logic [RES_W-1:0]  f_out_data;
  logic              frame_start;
  logic              rdc_hit;
  logic              rac_hit;

  assign f_in_valid = (cv_q == CV_CONV) && (cnt_q == DONE_CYC);
  // straight binary when high, MSB inverted for two's complement when low
  assign f_in_data  = {ADC_RESULT[RES_W-1] ^ ~pins_s2_q.code_format_sel, ADC_RESULT[RES_W-2:0]};

  assign rdc_hit     = (cv_q == CV_CONV) && !rac_q && (cnt_q == SYNC_RDC_CYC);
  assign rac_hit     = (cv_q == CV_CONV) && rac_q && (cnt_q == RAC_FRAME_CYC);
  assign frame_start = (sr_q == SR_IDLE) && serial_mode &&
                       (master_mode ? (rdc_hit | rac_hit) : f_out_valid);
  // the serial side pops only when a frame begins, so an unread slave port backs up the FIFO
  assign f_out_ready = serial_mode ? frame_start : 1'b1;

  sarrd_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .clk       (CORE_CLK),
    .rst_n     (RESET_N),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cv_q   <= CV_IDLE;
      cnt_q  <= '0;
      rac_q  <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      case (cv_q)
        CV_IDLE: begin
          // starts are refused while converting or while the FIFO is full
          if (start_fall && f_in_ready) begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
            rac_q  <= serial_mode & master_mode & pins_s2_q.read_after;
            cv_q   <= CV_CONV;
          end
        end
        CV_CONV: begin
          cnt_q <= cnt_q + CNT_W'(1);
          if (cnt_q == BUSY_FALL_CYC) begin
            if (rac_q) begin
              cv_q <= CV_HOLD;
            end else begin
              busy_q <= 1'b0;
              cv_q   <= CV_IDLE;
            end
          end
        end
        CV_HOLD: begin
          // one cycle after the frame marker drops
          if (sr_q == SR_IDLE) begin
            busy_q <= 1'b0;
            cv_q   <= CV_IDLE;
          end
        end
        default: begin
          cv_q <= CV_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // parallel port
  // ---------------------------------------------------------------
  logic [RES_W-1:0] data_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      data_q <= RESULT_RST;
    end else if (!serial_mode && f_out_valid) begin
      data_q <= f_out_data;
    end
  end

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  logic [RES_W-1:0]  shift_q;
  logic [4:0]        bit_q;
  logic [CNT_W-1:0]  tick_q;
  logic [1:0]        div_q;
  logic              sclk_q;
  logic              sync_q;
  logic              serial_out_line_q;
  logic              sr_master_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sr_q        <= SR_IDLE;
      shift_q     <= RESULT_RST;
      bit_q       <= '0;
      tick_q      <= '0;
      div_q       <= '0;
      sclk_q      <= 1'b0;
      sync_q      <= 1'b0;
      serial_out_line_q     <= 1'b0;
      sr_master_q <= 1'b0;
    end else begin
      case (sr_q)
        SR_IDLE: begin
          if (frame_start) begin
            // empty FIFO on the first read-during-convert frame sends zeros
            shift_q     <= f_out_valid ? f_out_data : RESULT_RST;
            serial_out_line_q     <= f_out_valid ? f_out_data[RES_W-1] : 1'b0;
            bit_q       <= '0;
            div_q       <= pins_s2_q.serial_clock_divider;
            sr_master_q <= master_mode;
            if (master_mode) begin
              sync_q <= 1'b1;
              tick_q <= lead_cyc(pins_s2_q.serial_clock_divider) - CNT_W'(1);
              sr_q   <= SR_LEAD;
            end else begin
              sr_q <= SR_SHIFT;
            end
          end
        end
        SR_LEAD: begin
          if (tick_q == '0) begin
            sclk_q <= 1'b1;
            tick_q <= half_cyc(div_q) - CNT_W'(1);
            sr_q   <= SR_SHIFT;
          end else begin
            tick_q <= tick_q - CNT_W'(1);
          end
        end
        SR_SHIFT: begin
          if (sr_master_q) begin
            if (tick_q != '0) begin
              tick_q <= tick_q - CNT_W'(1);
            end else begin
              tick_q <= half_cyc(div_q) - CNT_W'(1);
              sclk_q <= ~sclk_q;
              if (sclk_q) begin
                // falling edge: next bit out, daisy-chain bit in
                shift_q <= {shift_q[RES_W-2:0], pins_s2_q.serial_chain_in};
                serial_out_line_q <= shift_q[RES_W-2];
                bit_q   <= bit_q + 5'h01;
                if (bit_q == 5'(RES_W - 1)) begin
                  tick_q <= gap_cyc(div_q) - CNT_W'(1);
                  sr_q   <= SR_TAIL;
                end
              end
            end
          end else if (ext_fall) begin
            shift_q <= {shift_q[RES_W-2:0], pins_s2_q.serial_chain_in};
            serial_out_line_q <= shift_q[RES_W-2];
            bit_q   <= bit_q + 5'h01;
            if (bit_q == 5'(RES_W - 1)) begin
              sr_q <= SR_IDLE;
            end
          end
        end
        SR_TAIL: begin
          if (tick_q == '0) begin
            sync_q <= 1'b0;
            sr_q   <= SR_IDLE;
          end else begin
            tick_q <= tick_q - CNT_W'(1);
          end
        end
        default: begin
          sr_q <= SR_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output drivers
  // ---------------------------------------------------------------
  // enables follow the synchronised chip select, so they lag the pin by the synchroniser depth
  logic sync_oe_q;
  logic sclk_oe_q;
  logic serial_out_line_oe_q;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_oe_q  <= 1'b0;
      sclk_oe_q  <= 1'b0;
      serial_out_line_oe_q <= 1'b0;
    end else begin
      sync_oe_q  <= serial_mode & master_mode & cs_active;
      sclk_oe_q  <= serial_mode & master_mode & cs_active;
      serial_out_line_oe_q <= serial_mode & cs_active;
    end
  end

  assign BUSY  = busy_q;
  assign DATA  = data_q;
  assign SYNC  = '{o: sync_q, oe: sync_oe_q};
  assign SCLK  = '{o: sclk_q, oe: sclk_oe_q};
  assign SERIAL_OUT_LINE = '{o: serial_out_line_q, oe: serial_out_line_oe_q};
endmodule
`default_nettype wire

// ==== shared/sarrd_pkg.sv ====
// shared constants, pin bundles and serial timing decode for the converter readout
package sarrd_pkg;

  // ---------------------------------------------------------------
  // widths and clock
  // ---------------------------------------------------------------
  localparam int RES_W      = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 8;
  localparam int CLK_NS     = 25;

  // ---------------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------------
  localparam int T_CONV_NS       = 1250;
  localparam int T_SYNC_RDC_NS   = 500;
  localparam int T_EOC_BUSY_NS   = 10;
  localparam int T_DATA_BUSY_NS  = 20;
  localparam int CONV_MARGIN_CYC = 6;
  localparam int CONV_CYC        = T_CONV_NS / CLK_NS;
  localparam int EOC_BUSY_CYC    = (T_EOC_BUSY_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_BUSY_CYC   = (T_DATA_BUSY_NS + CLK_NS - 1) / CLK_NS;
  // margin keeps read-after-convert with the fastest divider inside its busy limit
  localparam logic [CNT_W-1:0] DONE_CYC      = CNT_W'(CONV_CYC - CONV_MARGIN_CYC);
  localparam logic [CNT_W-1:0] RAC_FRAME_CYC = CNT_W'(CONV_CYC - CONV_MARGIN_CYC + 1);
  localparam logic [CNT_W-1:0] BUSY_FALL_CYC = CNT_W'(CONV_CYC - CONV_MARGIN_CYC + EOC_BUSY_CYC + DATA_BUSY_CYC);
  localparam logic [CNT_W-1:0] SYNC_RDC_CYC  = CNT_W'(T_SYNC_RDC_NS / CLK_NS);

  // ---------------------------------------------------------------
  // serial clock timing per divider setting
  // ---------------------------------------------------------------
  localparam int T_LEAD_FAST_NS = 4;
  localparam int T_LEAD_SLOW_NS = 20;
  localparam int T_PER0_NS      = 25;
  localparam int T_PER1_NS      = 50;
  localparam int T_PER2_NS      = 100;
  localparam int T_PER3_NS      = 200;
  localparam int T_GAP0_NS      = 3;
  localparam int T_GAP1_NS      = 60;
  localparam int T_GAP2_NS      = 140;
  localparam int T_GAP3_NS      = 300;
  localparam logic [CNT_W-1:0] LEAD_FAST_CYC = CNT_W'((T_LEAD_FAST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LEAD_SLOW_CYC = CNT_W'((T_LEAD_SLOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] HALF0_CYC     = CNT_W'((T_PER0_NS + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [CNT_W-1:0] HALF1_CYC     = CNT_W'((T_PER1_NS + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [CNT_W-1:0] HALF2_CYC     = CNT_W'((T_PER2_NS + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [CNT_W-1:0] HALF3_CYC     = CNT_W'((T_PER3_NS + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [CNT_W-1:0] GAP0_CYC      = CNT_W'((T_GAP0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] GAP1_CYC      = CNT_W'((T_GAP1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] GAP2_CYC      = CNT_W'((T_GAP2_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] GAP3_CYC      = CNT_W'((T_GAP3_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [RES_W-1:0] RESULT_RST    = 16'h0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       conv_start_n;
    logic       cs_n;
    logic       ext_sclk;
    logic       serial_chain_in;
    logic       link_select;
    logic       code_format_sel;
    logic       slave_sel;
    logic       read_after;
    logic [1:0] serial_clock_divider;
  } sarrd_pins_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sarrd_tri_t;

  localparam sarrd_pins_t PINS_RST = '{conv_start_n: 1'b1, cs_n: 1'b1, default: '0};

  function automatic logic [CNT_W-1:0] half_cyc(input logic [1:0] d);
    case (d)
      2'b00:   half_cyc = HALF0_CYC;
      2'b01:   half_cyc = HALF1_CYC;
      2'b10:   half_cyc = HALF2_CYC;
      default: half_cyc = HALF3_CYC;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] gap_cyc(input logic [1:0] d);
    case (d)
      2'b00:   gap_cyc = GAP0_CYC;
      2'b01:   gap_cyc = GAP1_CYC;
      2'b10:   gap_cyc = GAP2_CYC;
      default: gap_cyc = GAP3_CYC;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] lead_cyc(input logic [1:0] d);
    lead_cyc = (d == 2'b00) ? LEAD_FAST_CYC : LEAD_SLOW_CYC;
  endfunction

endpackage
